// ===== ppt_pkg.sv
// Package with register map, field layout and timing constants of the process phase timer.
package ppt_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one 32-bit word each).
  // ****************************************************************
  localparam logic [7:0] PPT_OFS_CTRL = 8'h00;
  localparam logic [7:0] PPT_OFS_RUN = 8'h04;
  localparam logic [7:0] PPT_OFS_LEAD = 8'h08;
  localparam logic [7:0] PPT_OFS_AFTER = 8'h0c;
  localparam logic [7:0] PPT_OFS_BAND = 8'h10;
  localparam logic [7:0] PPT_OFS_STAT = 8'h14;
  localparam logic [7:0] PPT_OFS_IRQ = 8'h18;
  localparam logic [7:0] PPT_OFS_MASK = 8'h1c;
  localparam logic [7:0] PPT_OFS_COUNT = 8'h20;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int PPT_CTRL_EN_BIT = 0;
  localparam int PPT_CTRL_UNIT_LSB = 1;
  localparam int PPT_CTRL_LOWACT_BIT = 3;

  // ****************************************************************
  // Reset values and limits.
  // ****************************************************************
  localparam logic [31:0] PPT_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PPT_TIME_RST = 16'h0000;
  localparam logic [15:0] PPT_LEAD_MAX = 16'h270f;
  localparam logic [15:0] PPT_BAND_MAX = 16'h270f;
  localparam logic [15:0] PPT_AFTER_INF = 16'hffff;
  localparam logic [7:0] PPT_LIM_MS_HI = 8'h3b;
  localparam logic [7:0] PPT_LIM_MS_LO = 8'h3b;
  localparam logic [7:0] PPT_LIM_HM_HI = 8'h17;
  localparam logic [7:0] PPT_LIM_HM_LO = 8'h3b;
  localparam logic [7:0] PPT_LIM_DH_HI = 8'h63;
  localparam logic [7:0] PPT_LIM_DH_LO = 8'h17;

  // ****************************************************************
  // Timing: the time base ticks once per second at the 100 MHz clock.
  // ****************************************************************
  localparam longint PPT_CLK_HZ = 100000000;
  localparam longint PPT_TICK_S = 1;
  localparam longint PPT_TICK_CYC = PPT_CLK_HZ * PPT_TICK_S;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    PPT_UNIT_MS = 2'b00,
    PPT_UNIT_HM = 2'b01,
    PPT_UNIT_DH = 2'b10
  } ppt_unit_t;

  typedef enum logic [1:0] {
    PPT_IDLE = 2'b00,
    PPT_LEAD = 2'b01,
    PPT_RUN = 2'b10,
    PPT_AFTER = 2'b11
  } ppt_state_t;

  // Selected binary control inputs, asynchronous to the clock.
  typedef struct packed {
    logic start;
    logic cancel;
    logic stop;
    logic restart;
    logic ack;
  } ppt_ctl_t;

  // Interrupt events: run start, run end, after-run end, cancel.
  localparam int PPT_IRQ_W = 4;

endpackage : ppt_pkg

// ===== ppt_timer.sv
// Process phase timer: lead, run and after-run phases with Avalon-MM registers.
//
// Contract
// - Units mm:ss, hh:mm, dd:hh; mm:ss default.
// - Run time clamped per unit; default zero.
// - Lead phase 0 to 9999 seconds.
// - After-run -1 to 9999; -1 waits acknowledge.
// - End signal high during whole nonzero after-run.
// - Acknowledge edge ends nonzero after-run.
// - Start on rising start edge.
// - Start honoured only idle or after-run.
// - Cancel aborts during run phase only.
// - Stop level freezes lead and run.
// - Restart edge resets run count, run only.
// - Restart skips the lead phase.
// - Running output polarity selectable.
// - Nonzero band holds the run count until the band is first reached.
// - Zero band disables gating.
module ppt_timer
  import ppt_pkg::*;
#(
  parameter longint TICK_CYC = PPT_TICK_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Selected signals.
  input wire ppt_ctl_t ctl_in,
  input wire logic signed [15:0] actual_val,
  input wire logic signed [15:0] setpoint_val,
  // Indications.
  output logic run_out,
  output logic end_out,
  output logic irq
);

  // Elaboration stops on a tick length that the 32-bit divider cannot hold.
  if (TICK_CYC < 1 || TICK_CYC > 64'h0000_0000_ffff_ffff) begin : g_tick_chk
    $error("TICK_CYC out of range");
  end

  // Merge byte lanes of a write into an old value.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // Run duration in seconds from the two display fields and the unit.
  function automatic logic [23:0] run_secs(input logic [15:0] t, input ppt_unit_t u);
    logic [23:0] hi;
    logic [23:0] lo;
    hi = {16'h0000, t[15:8]};
    lo = {16'h0000, t[7:0]};
    unique case (u)
      PPT_UNIT_HM: return 24'((hi * 24'd3600) + (lo * 24'd60));
      PPT_UNIT_DH: return 24'((hi * 24'd86400) + (lo * 24'd3600));
      default: return 24'((hi * 24'd60) + lo);
    endcase
  endfunction : run_secs

  // ****************************************************************
  // Input synchronisers and edge detection.
  // ****************************************************************
  ppt_ctl_t sync1_r;
  ppt_ctl_t sync2_r;
  ppt_ctl_t prev_r;
  ppt_ctl_t rise;

  // Three flops per selected signal; the first is never looked at, the third only for edge detection.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= ctl_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Flops reset low, the idle level of every selector, so no false edge follows reset.
  assign rise = sync2_r & ~prev_r;

  // ****************************************************************
  // One-second time base.
  // ****************************************************************
  logic [31:0] div_r;
  logic tick;

  // Divider free-runs; a stopped timer simply skips ticks.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (div_r == 32'(TICK_CYC - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  // The first second of a phase may be short, as the divider is never restarted.
  assign tick = (div_r == 32'(TICK_CYC - 1));

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [31:0] ctrl_r;
  logic [15:0] run_r;
  logic [15:0] lead_r;
  logic [15:0] after_r;
  logic [15:0] band_r;
  logic [PPT_IRQ_W-1:0] irq_r;
  logic [PPT_IRQ_W-1:0] mask_r;
  logic [31:0] wr_val;
  logic wr_go;
  logic enable;
  ppt_unit_t unit;
  logic [7:0] lim_hi;
  logic [7:0] lim_lo;

  assign wr_go = avs_write && !avs_waitrequest;
  assign enable = ctrl_r[PPT_CTRL_EN_BIT];
  assign unit = ppt_unit_t'(ctrl_r[PPT_CTRL_UNIT_LSB +: 2]);

  // Field limits of the run time for the current unit.
  always_comb begin
    unique case (unit)
      PPT_UNIT_HM: begin
        lim_hi = PPT_LIM_HM_HI;
        lim_lo = PPT_LIM_HM_LO;
      end
      PPT_UNIT_DH: begin
        lim_hi = PPT_LIM_DH_HI;
        lim_lo = PPT_LIM_DH_LO;
      end
      default: begin
        lim_hi = PPT_LIM_MS_HI;
        lim_lo = PPT_LIM_MS_LO;
      end
    endcase
  end

  // Merged write value for the addressed register.
  always_comb begin
    unique case (avs_address)
      PPT_OFS_CTRL: wr_val = be_merge(ctrl_r, avs_writedata, avs_byteenable);
      PPT_OFS_RUN: wr_val = be_merge({16'h0000, run_r}, avs_writedata, avs_byteenable);
      PPT_OFS_LEAD: wr_val = be_merge({16'h0000, lead_r}, avs_writedata, avs_byteenable);
      PPT_OFS_AFTER: wr_val = be_merge({16'h0000, after_r}, avs_writedata, avs_byteenable);
      PPT_OFS_BAND: wr_val = be_merge({16'h0000, band_r}, avs_writedata, avs_byteenable);
      default: wr_val = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    endcase
  end

  // Writes clamp to the legal ranges; the run time only to the limits of the unit set when it is written.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= PPT_CTRL_RST;
      run_r <= PPT_TIME_RST;
      lead_r <= PPT_TIME_RST;
      after_r <= PPT_TIME_RST;
      band_r <= PPT_TIME_RST;
      mask_r <= '0;
    end else if (wr_go) begin
      unique case (avs_address)
        PPT_OFS_CTRL: begin
          ctrl_r <= {28'h000_0000, wr_val[3:0]};
          // Unit code 3 names no unit, so it falls back to the default.
          if (wr_val[2:1] == 2'b11) begin
            ctrl_r[2:1] <= PPT_UNIT_MS;
          end
        end
        PPT_OFS_RUN: begin
          run_r[15:8] <= (wr_val[15:8] > lim_hi) ? lim_hi : wr_val[15:8];
          run_r[7:0] <= (wr_val[7:0] > lim_lo) ? lim_lo : wr_val[7:0];
        end
        PPT_OFS_LEAD: lead_r <= (wr_val[15:0] > PPT_LEAD_MAX) ? PPT_LEAD_MAX : wr_val[15:0];
        PPT_OFS_AFTER: begin
          if (wr_val[15:0] == PPT_AFTER_INF) begin
            after_r <= PPT_AFTER_INF;
          end else begin
            after_r <= (wr_val[15:0] > PPT_LEAD_MAX) ? PPT_LEAD_MAX : wr_val[15:0];
          end
        end
        PPT_OFS_BAND: band_r <= (wr_val[15:0] > PPT_BAND_MAX) ? PPT_BAND_MAX : wr_val[15:0];
        PPT_OFS_MASK: mask_r <= wr_val[PPT_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Phase sequencer.
  // ****************************************************************
  ppt_state_t state_r;
  logic [23:0] cnt_r;
  logic in_band;
  logic signed [16:0] diff;
  logic [16:0] adiff;
  logic [PPT_IRQ_W-1:0] ev;
  logic band_hit_r;

  // One extra bit keeps the difference of two extreme values from wrapping.
  assign diff = 17'(actual_val) - 17'(setpoint_val);
  assign adiff = diff[16] ? 17'(-diff) : 17'(diff);
  assign in_band = (band_r == 16'h0000) || (adiff <= {1'b0, band_r});

  // The band only delays the first counted second; once reached, the run keeps
  // counting even if the actual value drifts out again.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      band_hit_r <= 1'b0;
    end else if (!enable || state_r != PPT_RUN) begin
      band_hit_r <= 1'b0;
    end else if (in_band) begin
      band_hit_r <= 1'b1;
    end
  end

  // Phases move idle, lead, run, after-run; zero durations fall through at once.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= PPT_IDLE;
      cnt_r <= '0;
    end else if (!enable) begin
      state_r <= PPT_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        PPT_IDLE: begin
          if (rise.start) begin
            state_r <= PPT_LEAD;
            cnt_r <= {8'h00, lead_r};
          end
        end
        PPT_LEAD: begin
          if (cnt_r == 24'h00_0000) begin
            state_r <= PPT_RUN;
            cnt_r <= run_secs(run_r, unit);
          end else if (tick && !sync2_r.stop) begin
            cnt_r <= cnt_r - 24'h00_0001;
          end
        end
        PPT_RUN: begin
          if (rise.cancel) begin
            state_r <= PPT_IDLE;
            cnt_r <= '0;
          end else if (rise.restart) begin
            cnt_r <= run_secs(run_r, unit);
          end else if (cnt_r == 24'h00_0000) begin
            state_r <= PPT_AFTER;
            cnt_r <= {8'h00, after_r};
          end else if (tick && !sync2_r.stop && (in_band || band_hit_r)) begin
            cnt_r <= cnt_r - 24'h00_0001;
          end
        end
        PPT_AFTER: begin
          if (rise.start) begin
            state_r <= PPT_LEAD;
            cnt_r <= {8'h00, lead_r};
          end else if (after_r != 16'h0000 && rise.ack) begin
            state_r <= PPT_IDLE;
            cnt_r <= '0;
          end else if (after_r != PPT_AFTER_INF) begin
            // Only a finite after-run times out; the endless one waits for ack.
            if (cnt_r == 24'h00_0000) begin
              state_r <= PPT_IDLE;
            end else if (tick) begin
              cnt_r <= cnt_r - 24'h00_0001;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs and interrupts.
  // ****************************************************************
  // Zero after-run shows no end pulse since end_out is gated off while after_r is zero.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_out <= 1'b0;
      end_out <= 1'b0;
    end else begin
      run_out <= ((state_r == PPT_LEAD) || (state_r == PPT_RUN)) ^ ctrl_r[PPT_CTRL_LOWACT_BIT];
      end_out <= enable && (state_r == PPT_AFTER) && (after_r != 16'h0000);
    end
  end

  // Events: run entered, after-run entered, after-run left, cancel taken.
  always_comb begin
    ev[0] = enable && state_r == PPT_LEAD && cnt_r == 24'h00_0000;
    ev[1] = enable && state_r == PPT_RUN && !rise.cancel && !rise.restart
            && cnt_r == 24'h00_0000;
    ev[2] = enable && state_r == PPT_AFTER && !rise.start
            && ((after_r != 16'h0000 && rise.ack)
            || (after_r != PPT_AFTER_INF && cnt_r == 24'h00_0000));
    ev[3] = enable && state_r == PPT_RUN && rise.cancel;
  end

  // Write one clears, but a new event in the same cycle wins.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_r <= '0;
    end else if (wr_go && avs_address == PPT_OFS_IRQ) begin
      irq_r <= (irq_r & ~wr_val[PPT_IRQ_W-1:0]) | ev;
    end else begin
      irq_r <= irq_r | ev;
    end
  end

  // Level output; it drops as soon as software clears or masks the last bit.
  assign irq = |(irq_r & mask_r);

  // ****************************************************************
  // Bus read path: one wait cycle per access keeps read data registered.
  // ****************************************************************
  logic ack_r;

  // Waitrequest drops for one cycle one cycle after a request appears.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Answering from a flop costs a cycle but keeps the bus path short.
  assign avs_waitrequest = !ack_r;

  // Read data is taken in the request cycle so it stands when waitrequest drops.
  // Read mux; unmapped offsets return zero.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_r) begin
      unique case (avs_address)
        PPT_OFS_CTRL: avs_readdata <= ctrl_r;
        PPT_OFS_RUN: avs_readdata <= {16'h0000, run_r};
        PPT_OFS_LEAD: avs_readdata <= {16'h0000, lead_r};
        PPT_OFS_AFTER: avs_readdata <= {16'h0000, after_r};
        PPT_OFS_BAND: avs_readdata <= {16'h0000, band_r};
        PPT_OFS_STAT: avs_readdata <= {28'h000_0000, end_out, in_band, state_r};
        PPT_OFS_IRQ: avs_readdata <= {28'h000_0000, irq_r};
        PPT_OFS_MASK: avs_readdata <= {28'h000_0000, mask_r};
        PPT_OFS_COUNT: avs_readdata <= {8'h00, cnt_r};
        default: avs_readdata <= '0;
      endcase
    end
  end

endmodule : ppt_timer

// ===== ppt_sel_model.sv
// Model of the selectors that feed control levels and analog values to the timer.
module ppt_sel_model
  import ppt_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Bench side.
  input wire ppt_ctl_t cmd,
  input wire logic signed [15:0] act,
  input wire logic signed [15:0] sp,
  // Timer side.
  output ppt_ctl_t ctl_in,
  output logic signed [15:0] actual_val,
  output logic signed [15:0] setpoint_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // Selector outputs refresh once a clock and are inactive after reset.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl_in <= '0;
      actual_val <= 16'sh0000;
      setpoint_val <= 16'sh0000;
    end else begin
      ctl_in <= cmd;
      actual_val <= act;
      setpoint_val <= sp;
    end
  end
endmodule : ppt_sel_model

// ===== ppt_timer_checker.sv
// Checker of the bus handshake and the timer indications.
module ppt_timer_checker
  import ppt_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Bus.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Signals and indications.
  input wire ppt_ctl_t ctl_in,
  input wire logic run_out,
  input wire logic end_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_r;
  logic low_r;
  logic mask_r;
  logic [1:0] calm_r;
  logic [2:0] stop_r;
  logic wr_ok;
  logic calm;
  logic running;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign calm = (calm_r == 2'd3);
  assign running = run_out ^ low_r;
  // Shadow of the settings; outputs lag a write, so checks wait until it settles.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      low_r <= 1'b0;
      mask_r <= 1'b0;
      calm_r <= 2'd3;
    end else if (wr_ok && avs_address == PPT_OFS_CTRL) begin
      en_r <= avs_writedata[PPT_CTRL_EN_BIT];
      low_r <= avs_writedata[PPT_CTRL_LOWACT_BIT];
      calm_r <= 2'd0;
    end else if (wr_ok && avs_address == PPT_OFS_MASK) begin
      mask_r <= |avs_writedata[3:0];
      calm_r <= 2'd0;
    end else if (!calm) begin
      calm_r <= calm_r + 2'd1;
    end
  end
  // Cycles of a held stop level; the synchroniser needs a few before it bites.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stop_r <= 3'd0;
    end else if (!(ctl_in.stop && !ctl_in.cancel && calm && en_r)) begin
      stop_r <= 3'd0;
    end else if (stop_r != 3'd6) begin
      stop_r <= stop_r + 3'd1;
    end
  end
  chk_wait_taken:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  chk_wait_idle:
    assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("stray answer");
  chk_rdata_hold:
    assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved");
  chk_off_quiet:
    assert property (calm && !en_r |-> !end_out && run_out == low_r) else $error("active when off");
  chk_end_not_run:
    assert property (calm && end_out |-> run_out == low_r) else $error("run shown in after-run");
  chk_stop_hold:
    assert property (stop_r == 3'd6 && running |=> running) else $error("stop did not freeze");
  chk_ack_end:
    assert property (end_out && $rose(ctl_in.ack) |-> ##[2:6] !end_out) else $error("ack ignored");
  chk_irq_masked:
    assert property (calm && !mask_r |-> !irq) else $error("masked interrupt raised");
endmodule : ppt_timer_checker

bind ppt_timer ppt_timer_checker chk_u (
  .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl_in(ctl_in),
  .run_out(run_out), .end_out(end_out), .irq(irq)
);

// ===== tb_top.sv
// Self-checking bench of the process phase timer.
module tb_top
  import ppt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  localparam int C = 3;
  localparam int R = 1;
  localparam int K = 0;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ppt_ctl_t cmd = '0;
  ppt_ctl_t ctl_in;
  logic signed [15:0] act = 16'sh0000;
  logic signed [15:0] sp = 16'sh0000;
  logic signed [15:0] actual_val;
  logic signed [15:0] setpoint_val;
  logic run_out;
  logic end_out;
  logic irq;
  logic [3:0] lane = 4'hf;
  logic [31:0] seed = 32'hef40_1906;
  logic [31:0] q;
  logic [31:0] w;
  logic [15:0] v;
  int fail_count = 0;
  int checked = 0;
  // A short tick keeps a second at 100 clocks.
  always #5 clock = ~clock;
  ppt_timer #(.TICK_CYC(100)) dut_u (
    .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl_in(ctl_in),
    .actual_val(actual_val), .setpoint_val(setpoint_val), .run_out(run_out),
    .end_out(end_out), .irq(irq));
  ppt_sel_model sel_u (.clock(clock), .nrst(nrst), .cmd(cmd), .act(act), .sp(sp),
    .ctl_in(ctl_in), .actual_val(actual_val), .setpoint_val(setpoint_val));
  // Random source and the run limits per unit.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] lim(input logic [1:0] u, input logic [15:0] x);
    logic [7:0] mh;
    logic [7:0] ml;
    mh = (u == 2'd2) ? 8'h63 : ((u == 2'd1) ? 8'h17 : 8'h3b);
    ml = (u == 2'd2) ? 8'h17 : 8'h3b;
    return {16'h0, (x[15:8] > mh) ? mh : x[15:8], (x[7:0] > ml) ? ml : x[7:0]};
  endfunction : lim
  // Comparison, counted and reported at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hang(input string nm);
    chk(nm, 32'h0, 32'h1);
    tally_and_finish();
  endtask : hang
  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= lane;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) hang("waitrequest");
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rg(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rg
  task automatic st(input logic [1:0] s, input string nm);
    bus(1'b0, 8'h14, 32'h0);
    chk(nm, {30'h0, s}, {30'h0, q[1:0]});
  endtask : st
  // Polls the phase; a hang here means a phase never came.
  task automatic wst(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h14, 32'h0);
      n++;
      if (n > 4000) hang("phase wait");
    end while (q[1:0] !== s);
  endtask : wst
  task automatic pul(input int i);
    cmd[i] <= 1'b1;
    repeat (8) @(posedge clock);
    cmd[i] <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pul
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence: defaults, limits, then each phase and control input.
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int a = 0; a <= 36; a += 4) begin
      // Status shows in-band at reset, since a zero band disables gating.
      rg(8'(a), (a == 20) ? 32'h0000_0004 : 32'h0, "reset");
    end
    for (int u = 0; u < 3; u++) begin
      bus(1'b1, 8'h00, 32'(u << 1));
      for (int k = 0; k < 5; k++) begin
        v = (k == 0) ? 16'hffff : 16'(rnd());
        bus(1'b1, 8'h04, {16'h0, v});
        rg(8'h04, lim(2'(u), v), "run limit");
      end
    end
    bus(1'b1, 8'h00, 32'h6);
    rg(8'h00, 32'h0, "unit three");
    bus(1'b1, 8'h08, 32'hffff);
    rg(8'h08, 32'h270f, "lead limit");
    bus(1'b1, 8'h0c, 32'h8000);
    rg(8'h0c, 32'h270f, "after limit");
    bus(1'b1, 8'h10, 32'hffff);
    rg(8'h10, 32'h270f, "band limit");
    bus(1'b1, 8'h24, 32'hffff_ffff);
    rg(8'h24, 32'h0, "unmapped");
    lane = 4'h0;
    bus(1'b1, 8'h00, 32'h1);
    lane = 4'hf;
    rg(8'h00, 32'h0, "no lanes");
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0c, 32'h2);
    bus(1'b1, 8'h1c, 32'hf);
    pul(S);
    st(0, "off");
    bus(1'b1, 8'h00, 32'h1);
    pul(S);
    st(1, "lead");
    pul(R);
    pul(C);
    pul(S);
    st(1, "lead kept");
    chk("run_out", 1, run_out);
    wst(2);
    rg(8'h18, 32'h1, "irq run");
    chk("irq", 1, irq);
    bus(1'b1, 8'h18, 32'h1);
    rg(8'h18, 32'h0, "irq clear");
    wst(3);
    repeat (2) @(posedge clock);
    chk("end_out", 1, end_out);
    wst(0);
    repeat (2) @(posedge clock);
    chk("end_out", 0, end_out);
    rg(8'h18, 32'h6, "irq ends");
    bus(1'b1, 8'h18, 32'hf);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, 32'h100);
    pul(S);
    wst(2);
    cmd.stop <= 1'b1;
    repeat (10) @(posedge clock);
    bus(1'b0, 8'h20, 32'h0);
    w = q;
    repeat (300) @(posedge clock);
    rg(8'h20, w, "frozen");
    cmd.stop <= 1'b0;
    repeat (300) @(posedge clock);
    pul(R);
    bus(1'b0, 8'h20, 32'h0);
    chk("reload", 1, 32'(q >= 59 && q <= 60));
    st(2, "restart");
    bus(1'b1, 8'h18, 32'hf);
    pul(C);
    st(0, "cancel");
    bus(1'b0, 8'h18, 32'h0);
    chk("irq cancel", 1, q[3]);
    bus(1'b1, 8'h1c, 32'h0);
    chk("masked", 0, irq);
    bus(1'b1, 8'h1c, 32'hf);
    chk("unmasked", 1, irq);
    bus(1'b1, 8'h0c, 32'hffff);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h10, 32'h5);
    act <= 16'sh0064;
    pul(S);
    wst(2);
    repeat (400) @(posedge clock);
    st(2, "band hold");
    act <= 16'shfffd;
    sp <= 16'shfff8;
    wst(3);
    repeat (2000) @(posedge clock);
    st(3, "endless");
    pul(C);
    st(3, "cancel late");
    pul(S);
    wst(2);
    wst(3);
    pul(K);
    st(0, "ack");
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h04, 32'h0102);
    pul(S);
    bus(1'b0, 8'h20, 32'h0);
    chk("hh:mm secs", 1, 32'(q >= 3719 && q <= 3720));
    bus(1'b1, 8'h00, 32'h5);
    pul(R);
    bus(1'b0, 8'h20, 32'h0);
    chk("dd:hh secs", 1, 32'(q >= 93599 && q <= 93600));
    pul(C);
    st(0, "cancel run");
    bus(1'b1, 8'h00, 32'h9);
    repeat (2) @(posedge clock);
    chk("low-active", 1, run_out);
    bus(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge clock);
    chk("off out", 0, run_out);
    tally_and_finish();
  end
endmodule : tb_top
